// [hdl/adc_control_sequencer.sv]
// Function
// - codes 0 to 3 route analog inputs 0-3, codes 4 to 28 connect nothing
// - codes 29, 30, 31 route temperature, dac output, fixed reference buffer
// - writing one to go starts conversion; go reads one while converting
// - go clears itself when conversion completes
// - enable bit 0 powers converter; cleared means converter off
// - format one: right justified, upper six high bits zero
// - format zero: left justified, lower six low bits zero
// - left: result 9..2 in high, 1..0 in low bits 7-6
// - right: result 9..8 in high bits 1-0, 7..0 in low
// - clock field codes 0,1,2,4,5,6 divide system clock by 2,8,32,4,16,64
// - clock field codes 3 and 7 select internal rc clock
// - reference code 00 supply, 10 external pin, others reserved
// - trigger field selects none, timers, comparator or logic cells
// - only a rising edge of the selected trigger starts conversion
// - timer 0 and 1 wrap pulses set their own interrupt flags
// - unimplemented control bits read as zero
// - control fields reset to zero; results keep contents across reset
// - completion sets done flag, updates results, clears go
// - clearing go early loads partial result, rest copy last bit
// - trigger rising edge sets go by hardware
// - full conversion lasts 11.5 bit periods
//
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adc_control_sequencer
	import adc_seq_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       reset_in,
	input  wire logic [2:0] addr_in,
	input  wire logic [7:0] wdata_in,
	input  wire logic       wr_in,
	input  wire logic       rd_in,
	output logic      [7:0] rdata_out,
	input  wire trig_s      trig_in,
	input  wire logic       rc_clock_in,
	input  wire logic       compare_in,
	output logic            sample_out,
	output logic      [3:0] analog_input_sel_out,
	output logic            temp_sel_out,
	output logic            dac_sel_out,
	output logic            fixed_ref_sel_out,
	output logic            pos_ref_external_out,
	output logic            converter_power_out,
	output logic            conversion_done_flag_out,
	output logic            timer0_flag_out,
	output logic            timer1_flag_out
);
	bus_req_s   req;
	logic [7:0] ctrl0_ff, ctrl1_ff, ctrl2_ff;
	logic [7:0] res_hi_ff, res_lo_ff;
	logic       busy_ff;
	logic [4:0] half_ff;
	logic [9:0] sar_ff;
	logic [3:0] bit_idx_ff;
	logic       last_bit_ff;
	logic [5:0] div_cnt_ff;
	logic       tick;
	logic [5:0] div_limit;
	clk_src_e   src;
	logic [5:0] trig_s1_ff, trig_s2_ff, trig_prev_ff;
	logic       rc_s1_ff, rc_s2_ff, rc_prev_ff;
	logic       cmp_s1_ff, cmp_s2_ff;
	logic       trig_sel, trig_prev_sel, trig_edge;
	logic       sw_go, sw_abort, start, finish, abort;
	logic [9:0] partial;
	logic [9:0] load_val;
	logic       load;
	logic       enable;
	logic       done_flag_ff, t0_flag_ff, t1_flag_ff;

	assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
	assign enable = ctrl0_ff[BIT_ENABLE];

	// synchronisers for outside signals
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			trig_s1_ff   <= '0;
			trig_s2_ff   <= '0;
			trig_prev_ff <= '0;
			rc_s1_ff     <= 1'b0;
			rc_s2_ff     <= 1'b0;
			rc_prev_ff   <= 1'b0;
			cmp_s1_ff    <= 1'b0;
			cmp_s2_ff    <= 1'b0;
		end else begin
			trig_s1_ff   <= trig_in;
			trig_s2_ff   <= trig_s1_ff;
			trig_prev_ff <= trig_s2_ff;
			rc_s1_ff     <= rc_clock_in;
			rc_s2_ff     <= rc_s1_ff;
			rc_prev_ff   <= rc_s2_ff;
			cmp_s1_ff    <= compare_in;
			cmp_s2_ff    <= cmp_s1_ff;
		end
	end

	always_comb begin
		case (ctrl2_ff[TRIG_MSB:TRIG_LSB])
			TRIG_T0: begin
				trig_sel      = trig_s2_ff[5];
				trig_prev_sel = trig_prev_ff[5];
			end
			TRIG_T1: begin
				trig_sel      = trig_s2_ff[4];
				trig_prev_sel = trig_prev_ff[4];
			end
			TRIG_T2: begin
				trig_sel      = trig_s2_ff[3];
				trig_prev_sel = trig_prev_ff[3];
			end
			TRIG_CMP1: begin
				trig_sel      = trig_s2_ff[2];
				trig_prev_sel = trig_prev_ff[2];
			end
			TRIG_LC1: begin
				trig_sel      = trig_s2_ff[1];
				trig_prev_sel = trig_prev_ff[1];
			end
			TRIG_LC2: begin
				trig_sel      = trig_s2_ff[0];
				trig_prev_sel = trig_prev_ff[0];
			end
			default: begin
				trig_sel      = 1'b0;
				trig_prev_sel = 1'b0;
			end
		endcase
	end

	assign trig_edge = trig_sel & ~trig_prev_sel;

	assign sw_go    = req.wr && req.addr == ADDR_CONTROL_0 &&
		req.wdata[BIT_GO];
	assign sw_abort = req.wr && req.addr == ADDR_CONTROL_0 &&
		!req.wdata[BIT_GO] && busy_ff;
	assign start  = !busy_ff && enable && (sw_go || trig_edge);
	assign finish = busy_ff && tick && half_ff == HALF_LAST;
	// abort on software clear or power off
	assign abort  = busy_ff && !finish && (sw_abort || !enable);

	always_comb begin
		case (ctrl1_ff[CCS_MSB:CCS_LSB])
			3'h0: begin
				src = SRC_SYSCLK;
				div_limit = 6'h00;
			end
			3'h1: begin
				src = SRC_SYSCLK;
				div_limit = 6'h03;
			end
			3'h2: begin
				src = SRC_SYSCLK;
				div_limit = 6'h0F;
			end
			3'h4: begin
				src = SRC_SYSCLK;
				div_limit = 6'h01;
			end
			3'h5: begin
				src = SRC_SYSCLK;
				div_limit = 6'h07;
			end
			3'h6: begin
				src = SRC_SYSCLK;
				div_limit = 6'h1F;
			end
			3'h3, 3'h7: begin
				src = SRC_RC;
				div_limit = 6'h00;
			end
			default: begin
				src = SRC_NONE;
				div_limit = 6'h00;
			end
		endcase
	end

	// half bit period tick: every divide/2 system clocks, or each rc edge
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			div_cnt_ff <= '0;
		else if (!busy_ff || src != SRC_SYSCLK || div_cnt_ff == div_limit)
			div_cnt_ff <= '0;
		else
			div_cnt_ff <= div_cnt_ff + 6'h01;
	end

	always_comb begin
		case (src)
			SRC_SYSCLK: tick = busy_ff && div_cnt_ff == div_limit;
			SRC_RC:     tick = busy_ff && (rc_s2_ff ^ rc_prev_ff);
			default:    tick = 1'b0;
		endcase
	end

	// successive approximation sequence
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			busy_ff     <= 1'b0;
			half_ff     <= '0;
			sar_ff      <= '0;
			bit_idx_ff  <= '0;
			last_bit_ff <= 1'b0;
		end else if (start) begin
			busy_ff     <= 1'b1;
			half_ff     <= '0;
			sar_ff      <= '0;
			bit_idx_ff  <= 4'(RESULT_BITS - 1);
			last_bit_ff <= 1'b0;
		end else if (finish || abort) begin
			busy_ff <= 1'b0;
		end else if (tick) begin
			half_ff <= half_ff + 5'h01;
			// decide one bit on every odd half period after the first
			if (half_ff[0] && half_ff > 5'h01 &&
				bit_idx_ff < 4'(RESULT_BITS)) begin
				sar_ff[bit_idx_ff] <= cmp_s2_ff;
				last_bit_ff        <= cmp_s2_ff;
				bit_idx_ff         <= bit_idx_ff - 4'h1;
			end
		end
	end

	// unresolved bits copy the last resolved bit
	always_comb begin
		partial = sar_ff;
		for (int i = 0; i < RESULT_BITS; i++) begin
			if (bit_idx_ff < 4'(RESULT_BITS) && i <= int'(bit_idx_ff))
				partial[i] = last_bit_ff;
		end
	end

	assign load     = finish || abort;
	assign load_val = finish ? sar_ff : partial;
	assign sample_out = busy_ff && half_ff < 5'h02;

	// control registers
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			ctrl0_ff <= CTRL_RESET;
			ctrl1_ff <= CTRL_RESET;
			ctrl2_ff <= CTRL_RESET;
		end else begin
			if (req.wr && req.addr == ADDR_CONTROL_1)
				ctrl1_ff <= req.wdata & MASK_CTRL1;
			if (req.wr && req.addr == ADDR_CONTROL_2)
				ctrl2_ff <= req.wdata & MASK_CTRL2;
			if (req.wr && req.addr == ADDR_CONTROL_0) begin
				// go bit via write, kept only if a start is accepted or a conversion is running
				ctrl0_ff <= req.wdata & MASK_CTRL0 & ~8'h02;
				ctrl0_ff[BIT_GO] <= start || (busy_ff && !abort &&
					!finish);
			end else begin
				ctrl0_ff[BIT_GO] <= start || (busy_ff && !abort &&
					!finish);
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (load) begin
			if (ctrl1_ff[BIT_FORMAT]) begin
				res_hi_ff <= {6'h00, load_val[9:8]};
				res_lo_ff <= load_val[7:0];
			end else begin
				res_hi_ff <= load_val[9:2];
				res_lo_ff <= {load_val[1:0], 6'h00};
			end
		end else begin
			if (req.wr && req.addr == ADDR_RESULT_HIGH)
				res_hi_ff <= req.wdata;
			if (req.wr && req.addr == ADDR_RESULT_LOW)
				res_lo_ff <= req.wdata;
		end
	end

	// sticky flags, set wins over clear
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in) begin
			done_flag_ff <= 1'b0;
			t0_flag_ff   <= 1'b0;
			t1_flag_ff   <= 1'b0;
		end else begin
			if (req.wr && req.addr == ADDR_STATUS) begin
				done_flag_ff <= done_flag_ff & ~req.wdata[0];
				t0_flag_ff   <= t0_flag_ff & ~req.wdata[1];
				t1_flag_ff   <= t1_flag_ff & ~req.wdata[2];
			end
			if (load)
				done_flag_ff <= 1'b1;
			if (trig_s2_ff[5] && !trig_prev_ff[5])
				t0_flag_ff <= 1'b1;
			if (trig_s2_ff[4] && !trig_prev_ff[4])
				t1_flag_ff <= 1'b1;
		end
	end

	// read data, unimplemented bits masked to zero
	always_ff @(posedge clk_in or posedge reset_in) begin
		if (reset_in)
			rdata_out <= '0;
		else if (req.rd) begin
			case (req.addr)
				ADDR_CONTROL_0:   rdata_out <= ctrl0_ff & MASK_CTRL0;
				ADDR_CONTROL_1:   rdata_out <= ctrl1_ff & MASK_CTRL1;
				ADDR_CONTROL_2:   rdata_out <= ctrl2_ff & MASK_CTRL2;
				ADDR_RESULT_HIGH: rdata_out <= res_hi_ff;
				ADDR_RESULT_LOW:  rdata_out <= res_lo_ff;
				ADDR_STATUS:      rdata_out <= {5'h00, t1_flag_ff,
					t0_flag_ff, done_flag_ff};
				default:          rdata_out <= '0;
			endcase
		end else
			rdata_out <= '0;
	end

	always_comb begin
		analog_input_sel_out = '0;
		if (ctrl0_ff[CHS_MSB:CHS_LSB] <= CH_LAST_INPUT)
			analog_input_sel_out[ctrl0_ff[CHS_LSB+1:CHS_LSB]] = 1'b1;
	end
	assign temp_sel_out      = ctrl0_ff[CHS_MSB:CHS_LSB] == CH_TEMP;
	assign dac_sel_out       = ctrl0_ff[CHS_MSB:CHS_LSB] == CH_DAC;
	assign fixed_ref_sel_out = ctrl0_ff[CHS_MSB:CHS_LSB] == CH_FIXED_REF;
	// external reference only for code 10
	assign pos_ref_external_out =
		ctrl1_ff[PREF_MSB:PREF_LSB] == PREF_EXTERNAL;
	assign converter_power_out      = enable;
	assign conversion_done_flag_out = done_flag_ff;
	assign timer0_flag_out          = t0_flag_ff;
	assign timer1_flag_out          = t1_flag_ff;
endmodule
`default_nettype wire

// [hdl/adc_seq_pkg.sv]
package adc_seq_pkg;
	// register addresses (plain port, no offsets documented)
	localparam logic [2:0] ADDR_CONTROL_0   = 3'h0;
	localparam logic [2:0] ADDR_CONTROL_1   = 3'h1;
	localparam logic [2:0] ADDR_CONTROL_2   = 3'h2;
	localparam logic [2:0] ADDR_RESULT_HIGH = 3'h3;
	localparam logic [2:0] ADDR_RESULT_LOW  = 3'h4;
	localparam logic [2:0] ADDR_STATUS      = 3'h5;

	localparam int BIT_ENABLE  = 0;
	localparam int BIT_GO      = 1;
	localparam int CHS_LSB     = 2;
	localparam int CHS_MSB     = 6;
	localparam int PREF_LSB    = 0;
	localparam int PREF_MSB    = 1;
	localparam int CCS_LSB     = 4;
	localparam int CCS_MSB     = 6;
	localparam int BIT_FORMAT  = 7;
	localparam int TRIG_LSB    = 4;
	localparam int TRIG_MSB    = 7;

	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_CTRL0 = 8'h7F;
	localparam logic [7:0] MASK_CTRL1 = 8'hF3;
	localparam logic [7:0] MASK_CTRL2 = 8'hF0;

	localparam logic [4:0] CH_LAST_INPUT = 5'h03;
	localparam logic [4:0] CH_TEMP       = 5'h1D;
	localparam logic [4:0] CH_DAC        = 5'h1E;
	localparam logic [4:0] CH_FIXED_REF  = 5'h1F;

	localparam logic [1:0] PREF_SUPPLY   = 2'h0;
	localparam logic [1:0] PREF_EXTERNAL = 2'h2;

	localparam logic [3:0] TRIG_NONE   = 4'h0;
	localparam logic [3:0] TRIG_T0     = 4'h3;
	localparam logic [3:0] TRIG_T1     = 4'h4;
	localparam logic [3:0] TRIG_T2     = 4'h5;
	localparam logic [3:0] TRIG_CMP1   = 4'h6;
	localparam logic [3:0] TRIG_LC1    = 4'h8;
	localparam logic [3:0] TRIG_LC2    = 4'h9;

	// conversion length in half bit periods: 11.5 periods
	localparam int HALF_PERIODS_X2 = 23;
	localparam int RESULT_BITS     = 10;
	localparam logic [4:0] HALF_LAST = 5'h16;

	typedef enum logic [1:0] {
		SRC_NONE,
		SRC_SYSCLK,
		SRC_RC
	} clk_src_e;

	typedef struct packed {
		logic       timer0_wrap;
		logic       timer1_wrap;
		logic       timer2_period_hit;
		logic       comparator1_synced;
		logic       logic_cell1_output;
		logic       logic_cell2_output;
	} trig_s;

	typedef struct packed {
		logic [2:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_s;
endpackage

// [bench/adc_control_sequencer_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_seq_checker
	import adc_seq_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       reset_in,
	input wire logic [2:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic       wr_in,
	input wire logic       rd_in,
	input wire logic [7:0] rdata_out,
	input wire trig_s      trig_in,
	input wire logic [3:0] analog_input_sel_out,
	input wire logic       temp_sel_out,
	input wire logic       dac_sel_out,
	input wire logic       fixed_ref_sel_out,
	input wire logic       pos_ref_external_out,
	input wire logic       converter_power_out,
	input wire logic       timer0_flag_out,
	input wire logic       timer1_flag_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (reset_in);
	wire       w0  = wr_in && addr_in == ADDR_CONTROL_0;
	wire [4:0] chs = wdata_in[6:2];
	wire [1:0] lo2 = wdata_in[3:2];

	chk_input_decode: assert property (w0 |=> analog_input_sel_out ==
		($past(chs) < 5'h04 ? 4'h1 << $past(lo2) : 4'h0))
		else $error("analog input select wrong");
	chk_special_chan: assert property (w0 |=>
		{temp_sel_out, dac_sel_out, fixed_ref_sel_out} == {$past(chs) ==
		CH_TEMP, $past(chs) == CH_DAC, $past(chs) == CH_FIXED_REF})
		else $error("special channel select wrong");
	chk_power_bit: assert property (w0 |=>
		converter_power_out == $past(wdata_in[0]))
		else $error("converter power wrong");
	chk_ref_select: assert property (wr_in && addr_in == ADDR_CONTROL_1
		|=> pos_ref_external_out == ($past(wdata_in[1:0]) == PREF_EXTERNAL))
		else $error("reference select wrong");
	chk_ctrl0_pad: assert property (rd_in && addr_in == ADDR_CONTROL_0
		|=> !rdata_out[7]) else $error("control 0 bit 7 not zero");
	chk_ctrl1_pad: assert property (rd_in && addr_in == ADDR_CONTROL_1
		|=> rdata_out[3:2] == 2'h0) else $error("control 1 pad not zero");
	chk_ctrl2_pad: assert property (rd_in && addr_in == ADDR_CONTROL_2
		|=> rdata_out[3:0] == 4'h0) else $error("control 2 pad not zero");
	chk_rdata_idle: assert property (!rd_in |=> rdata_out == 8'h00)
		else $error("read data not zero without read");
	chk_timer0_flag: assert property ($rose(trig_in.timer0_wrap)
		|-> ##[1:8] timer0_flag_out) else $error("timer 0 flag not set");
	chk_timer1_flag: assert property ($rose(trig_in.timer1_wrap)
		|-> ##[1:8] timer1_flag_out) else $error("timer 1 flag not set");
endmodule
bind adc_control_sequencer adc_seq_checker i_adc_seq_checker (.clk_in,
	.reset_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .trig_in,
	.analog_input_sel_out, .temp_sel_out, .dac_sel_out, .fixed_ref_sel_out,
	.pos_ref_external_out, .converter_power_out, .timer0_flag_out,
	.timer1_flag_out);
`default_nettype wire

// [bench/adc_control_sequencer_test.sv]
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin \
	miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module adc_control_sequencer_test
	import adc_seq_pkg::*;
;
	logic       clk_in = 0;
	logic       reset_in = 1;
	logic [2:0] addr = 0;
	logic [7:0] wdata = 0;
	logic       wr = 0;
	logic       rd = 0;
	logic       rc = 0;
	logic       cmp = 0;
	trig_s      trig = '0;
	logic [7:0] rdata;
	logic [3:0] ain;
	logic       tsel, dsel, fsel, pref, pwr, done, t0f, t1f;
	int         miscompares = 0;
	int         cmp_count = 0;
	int         cyc = 0;
	logic [4:0] ch_tab [9] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h1C,
		5'h1D, 5'h1E, 5'h1F};
	logic [2:0] ccs_tab [8] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h3, 3'h7};
	int         half_tab [8] = '{1, 4, 16, 2, 8, 32, 4, 4};
	logic [3:0] trig_tab [6] = '{TRIG_T0, TRIG_T1, TRIG_T2, TRIG_CMP1,
		TRIG_LC1, TRIG_LC2};

	adc_control_sequencer i_adc_control_sequencer (.clk_in(clk_in),
		.reset_in(reset_in), .addr_in(addr), .wdata_in(wdata), .wr_in(wr),
		.rd_in(rd), .rdata_out(rdata), .trig_in(trig), .rc_clock_in(rc),
		.compare_in(cmp), .sample_out(), .analog_input_sel_out(ain),
		.temp_sel_out(tsel), .dac_sel_out(dsel), .fixed_ref_sel_out(fsel),
		.pos_ref_external_out(pref), .converter_power_out(pwr),
		.conversion_done_flag_out(done), .timer0_flag_out(t0f),
		.timer1_flag_out(t1f));

	initial forever #20 clk_in = ~clk_in;
	// free running rc clock: one half bit period every 4 clocks
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc % 4 == 0)
			rc <= ~rc;
	end

	task automatic wrap_up();
		if (miscompares == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_in);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk_in);
		wr <= 1'b0;
		#1;
	endtask

	task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_in);
		rd <= 1'b0;
		#1;
		`CHK("register", e, rdata)
	endtask

	function automatic logic [6:0] ch_exp(input logic [4:0] c);
		ch_exp = {c < 5'h04 ? 4'h1 << c[1:0] : 4'h0, c == 5'h1D, c == 5'h1E,
			c == 5'h1F};
	endfunction

	task automatic convert(input logic [2:0] ccs, input int h, input logic f);
		int t;
		wr_reg(ADDR_CONTROL_1, {f, ccs, 4'h0});
		wr_reg(ADDR_STATUS, 8'h07);
		wr_reg(ADDR_CONTROL_0, 8'h03);
		t = cyc;
		`CHK("done", 1'b0, done)
		rd_chk(ADDR_CONTROL_0, 8'h03);
		for (int n = 0; n < 3000 && done !== 1'b1; n++)
			@(posedge clk_in);
		t = cyc - t;
		`CHK("length", 1'b1, t >= 21 * h && t <= 24 * h + 8)
		rd_chk(ADDR_CONTROL_0, 8'h01);
	endtask

	task automatic edge_try(input int b, input logic e);
		@(posedge clk_in);
		trig[b] <= 1'b1;
		repeat (40) @(posedge clk_in);
		#1;
		`CHK("trigger", e, done)
	endtask

	initial begin
		repeat (20000) @(posedge clk_in);
		miscompares++;
		wrap_up();
	end

	initial begin
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_chk(ADDR_CONTROL_0, 8'h00);
		rd_chk(ADDR_CONTROL_1, 8'h00);
		rd_chk(ADDR_CONTROL_2, 8'h00);
		wr_reg(ADDR_CONTROL_0, 8'hFE);
		rd_chk(ADDR_CONTROL_0, 8'h7C);
		wr_reg(ADDR_CONTROL_1, 8'hFF);
		rd_chk(ADDR_CONTROL_1, 8'hF3);
		wr_reg(ADDR_CONTROL_2, 8'hFF);
		rd_chk(ADDR_CONTROL_2, 8'hF0);
		wr_reg(ADDR_CONTROL_2, 8'h00);
		for (int r = 0; r < 4; r++) begin
			wr_reg(ADDR_CONTROL_1, 8'(r));
			`CHK("reference", r == 2, pref)
		end
		foreach (ch_tab[k]) begin
			wr_reg(ADDR_CONTROL_0, {1'b0, ch_tab[k], 2'b01});
			`CHK("channel", ch_exp(ch_tab[k]), {ain, tsel, dsel, fsel})
		end
		wr_reg(ADDR_CONTROL_0, 8'h00);
		`CHK("power", 1'b0, pwr)
		wr_reg(ADDR_CONTROL_0, 8'h01);
		`CHK("power", 1'b1, pwr)
		for (int i = 0; i < 8; i++) begin
			cmp <= (i > 2);
			convert(ccs_tab[i], half_tab[i], i[0]);
			rd_chk(ADDR_RESULT_HIGH, i < 3 ? 8'h00 : i[0] ? 8'h03 : 8'hFF);
			rd_chk(ADDR_RESULT_LOW, i < 3 ? 8'h00 : i[0] ? 8'hFF : 8'hC0);
		end
		// abort part way: two bits resolved as one, the rest copy the last
		wr_reg(ADDR_CONTROL_1, 8'h60);
		wr_reg(ADDR_STATUS, 8'h07);
		wr_reg(ADDR_CONTROL_0, 8'h03);
		repeat (200) @(posedge clk_in);
		wr_reg(ADDR_CONTROL_0, 8'h01);
		`CHK("abort done", 1'b1, done)
		rd_chk(ADDR_CONTROL_0, 8'h01);
		rd_chk(ADDR_RESULT_HIGH, 8'hFF);
		rd_chk(ADDR_RESULT_LOW, 8'hC0);
		wr_reg(ADDR_CONTROL_1, 8'h80);
		foreach (trig_tab[k]) begin
			wr_reg(ADDR_STATUS, 8'h07);
			wr_reg(ADDR_CONTROL_2, {trig_tab[k], 4'h0});
			edge_try(5 - k, 1'b1);
			`CHK("timer0", k == 0, t0f)
			`CHK("timer1", k == 1, t1f)
			wr_reg(ADDR_STATUS, 8'h07);
			edge_try(5 - k, 1'b0);
			trig[5 - k] <= 1'b0;
		end
		wr_reg(ADDR_CONTROL_2, 8'h00);
		edge_try(3, 1'b0);
		trig[3] <= 1'b0;
		wr_reg(ADDR_CONTROL_0, 8'h00);
		wr_reg(ADDR_CONTROL_2, {TRIG_T0, 4'h0});
		edge_try(5, 1'b0);
		trig[5] <= 1'b0;
		reset_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		reset_in <= 1'b0;
		rd_chk(ADDR_RESULT_HIGH, 8'h03);
		rd_chk(ADDR_RESULT_LOW, 8'hFF);
		rd_chk(ADDR_CONTROL_2, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
